// ### verilog/egd_top.sv
/*
  Encoder output pulse divider and electronic gear with an APB register file.
  Assumes encoder and reference inputs are synchronous to pclk and that the
  reference pulse is a one-cycle strobe per reference count.
*/
`timescale 1ns/100ps
`default_nettype none
module egd_top (
  // APB slave
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Motor encoder quadrature
  input wire logic enc_a,
  input wire logic enc_b,
  // Divided outputs
  output logic divided_phase_a_out,
  output logic divided_phase_a_out_n,
  output logic divided_phase_b_out,
  output logic divided_phase_b_out_n,
  // Reference pulses and geared counts
  input wire logic ref_pulse,
  input wire logic ref_dir,
  output logic gear_step,
  output logic gear_dir,
  output logic gear_busy
);
  logic [15:0] output_pulse_divider;
  logic [15:0] gear_ratio_numerator;
  logic [15:0] gear_ratio_denominator;
  logic [3:0] enc_config;
  logic [15:0] act_divider;
  logic [2:0] act_config;
  logic [31:0] gear_position;
  logic [1:0] enc_prev;
  logic [1:0] enc_move;
  logic [16:0] num_eff;
  logic [16:0] den_eff;
  logic [16:0] ppr;
  logic signed [18:0] acc;
  logic signed [18:0] next_acc;
  logic out_move;
  logic out_up;
  egd_pkg::egd_phase_type phase;
  logic signed [23:0] rem;
  logic signed [23:0] next_rem;
  logic signed [23:0] num_s;
  logic signed [23:0] den_s;
  logic drain_up;
  logic drain_dn;
  logic pos_mode;
  logic wr_en;
  logic setup;
  logic restart;

  // Address decode, shared by write enable and error
  function automatic logic egd_mapped(input logic [11:0] a);
    egd_mapped = (a == egd_pkg::OFS_DIVIDER) || (a == egd_pkg::OFS_NUMER) ||
                 (a == egd_pkg::OFS_DENOM) || (a == egd_pkg::OFS_CONFIG) ||
                 (a == egd_pkg::OFS_CTRL) || (a == egd_pkg::OFS_STATUS) ||
                 (a == egd_pkg::OFS_POSITION);
  endfunction : egd_mapped

  // Quadrature step decode: {valid, up}; forward order 00,10,11,01
  function automatic logic [1:0] egd_quad(input logic [1:0] o, input logic [1:0] n);
    logic [3:0] t;
    t = {o, n};
    case (t)
      4'h2, 4'hB, 4'hD, 4'h4: egd_quad = 2'h3;
      4'h1, 4'h7, 4'hE, 4'h8: egd_quad = 2'h2;
      default: egd_quad = 2'h0;
    endcase
  endfunction : egd_quad

  // Bus handshake: zero wait states
  assign pready = 1'b1;
  assign setup = psel && !penable;
  assign wr_en = psel && penable && pwrite && egd_mapped(paddr);
  assign pslverr = psel && penable && !egd_mapped(paddr);
  assign restart = wr_en && (paddr == egd_pkg::OFS_CTRL) && pwdata[egd_pkg::CTRL_RESTART];
  assign pos_mode = enc_config[egd_pkg::CFG_POS_MODE];

  // Stored settings written by software
  // sixteen bit divider
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      output_pulse_divider <= egd_pkg::RST_DIVIDER;
      gear_ratio_numerator <= egd_pkg::RST_NUMER;
      gear_ratio_denominator <= egd_pkg::RST_DENOM;
      enc_config <= egd_pkg::RST_CONFIG;
    end
    else if (wr_en)
    begin
      if (paddr == egd_pkg::OFS_DIVIDER)
        output_pulse_divider <= pwdata[15:0];
      if (paddr == egd_pkg::OFS_NUMER)
        gear_ratio_numerator <= (pwdata[15:0] == 16'h0000) ? 16'h0001 : pwdata[15:0];
      if (paddr == egd_pkg::OFS_DENOM)
        gear_ratio_denominator <= (pwdata[15:0] == 16'h0000) ? 16'h0001 : pwdata[15:0];
      if (paddr == egd_pkg::OFS_CONFIG)
        enc_config <= pwdata[3:0];
    end
  end

  // Working divider settings, reloaded only by a restart
  // restart applies divider
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      act_divider <= egd_pkg::RST_DIVIDER;
      act_config <= egd_pkg::RST_CONFIG[2:0];
    end
    else if (restart)
    begin
      act_divider <= output_pulse_divider;
      act_config <= enc_config[2:0];
    end
  end

  // Read data captured in the setup cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h00000000;
    else if (setup)
    begin
      case (paddr)
        egd_pkg::OFS_DIVIDER: prdata <= {16'h0000, output_pulse_divider};
        egd_pkg::OFS_NUMER: prdata <= {16'h0000, gear_ratio_numerator};
        egd_pkg::OFS_DENOM: prdata <= {16'h0000, gear_ratio_denominator};
        egd_pkg::OFS_CONFIG: prdata <= {28'h0000000, enc_config};
        egd_pkg::OFS_STATUS: prdata <= {12'h000, gear_busy, act_config, act_divider};
        egd_pkg::OFS_POSITION: prdata <= gear_position;
        default: prdata <= 32'h00000000;
      endcase
    end
  end

  // Effective divider ratio num_eff / den_eff
  always_comb
  begin
    case (act_config[2:1])
      egd_pkg::RES_13: ppr = egd_pkg::PPR_13;
      egd_pkg::RES_16: ppr = egd_pkg::PPR_16;
      default: ppr = egd_pkg::PPR_17;
    endcase
    num_eff = {1'b0, act_divider};
    den_eff = ppr;
    if (act_config[egd_pkg::CFG_QUAD])
    begin
      den_eff = egd_pkg::QUAD_MODULUS;
      if (act_divider == 16'h0000)
        num_eff = egd_pkg::QUAD_MODULUS;
    end
    else
    begin
      if (num_eff < egd_pkg::DIV_MIN)
        num_eff = egd_pkg::DIV_MIN;
      else if (num_eff > ppr)
        num_eff = ppr;
    end
  end

  // Input step and divided step
  // scale encoder counts
  assign enc_move = egd_quad(enc_prev, {enc_a, enc_b});
  always_comb
  begin
    next_acc = acc;
    out_move = 1'b0;
    out_up = enc_move[0];
    if (enc_move[1] && enc_move[0])
    begin
      next_acc = acc + $signed({2'b00, num_eff});
      if (next_acc >= $signed({2'b00, den_eff}))
      begin
        next_acc = next_acc - $signed({2'b00, den_eff});
        out_move = 1'b1;
      end
    end
    else if (enc_move[1])
    begin
      next_acc = acc - $signed({2'b00, num_eff});
      if (next_acc < 19'sd0)
      begin
        next_acc = next_acc + $signed({2'b00, den_eff});
        out_move = 1'b1;
      end
    end
  end

  // Encoder history
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      enc_prev <= 2'h0;
    else
      enc_prev <= {enc_a, enc_b};
  end

  // Divider remainder, cleared on restart
  // divider remainder
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      acc <= 19'sd0;
    else if (restart)
      acc <= 19'sd0;
    else
      acc <= next_acc;
  end

  // Divided output phase walks the Gray cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      phase <= egd_pkg::PH0;
    else if (out_move)
    begin
      case (phase)
        egd_pkg::PH0: phase <= out_up ? egd_pkg::PH1 : egd_pkg::PH3;
        egd_pkg::PH1: phase <= out_up ? egd_pkg::PH2 : egd_pkg::PH0;
        egd_pkg::PH2: phase <= out_up ? egd_pkg::PH3 : egd_pkg::PH1;
        egd_pkg::PH3: phase <= out_up ? egd_pkg::PH0 : egd_pkg::PH2;
        default: phase <= egd_pkg::PH0;
      endcase
    end
  end

  // Line driver pairs: A leads B going forward
  always_comb
  begin
    divided_phase_a_out = phase[0];
    divided_phase_b_out = phase[1];
    divided_phase_a_out_n = !divided_phase_a_out;
    divided_phase_b_out_n = !divided_phase_b_out;
  end

  // Gear remainder: add numerator per forward pulse, subtract it per reverse pulse, drain one denominator per cycle
  // gear ratio scaling
  assign num_s = $signed({8'h00, gear_ratio_numerator});
  assign den_s = $signed({8'h00, gear_ratio_denominator});
  assign drain_up = rem >= den_s;
  assign drain_dn = rem <= -den_s;
  assign gear_busy = drain_up || drain_dn;
  always_comb
  begin
    next_rem = rem;
    if (pos_mode && ref_pulse)
      next_rem = ref_dir ? next_rem - num_s : next_rem + num_s;
    if (drain_up)
      next_rem = next_rem - den_s;
    else if (drain_dn)
      next_rem = next_rem + den_s;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      rem <= 24'sd0;
    else
      rem <= next_rem;
  end

  // Geared count strobe and position
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      gear_step <= 1'b0;
      gear_dir <= 1'b0;
      gear_position <= 32'h00000000;
    end
    else
    begin
      gear_step <= gear_busy;
      if (gear_busy)
      begin
        gear_dir <= drain_dn;
        gear_position <= drain_dn ? gear_position - 32'h00000001 : gear_position + 32'h00000001;
      end
    end
  end

  // Checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_ref_fwd;
    pos_mode && ref_pulse && !ref_dir && !gear_busy && (rem == 24'sd0) &&
    (gear_ratio_numerator >= gear_ratio_denominator);
  endsequence

  a_div_restart_only: assert property ($changed(act_divider) |-> $past(restart))
    else $error("working divider changed without restart");
  a_one_to_one: assert property (act_config[0] && act_divider == 16'h0000 && enc_move[1]
    |=> phase != $past(phase))
    else $error("one to one mode dropped a count");
  a_clamp_13bit: assert property (!act_config[0] && act_config[2:1] == 2'h0 &&
    act_divider > 16'h0800 |-> num_eff == 17'h00800)
    else $error("13-bit clamp missing");
  a_serial_floor: assert property (!act_config[0] && act_divider < 16'h0010
    |-> num_eff == 17'h00010)
    else $error("serial divider below floor");
  a_quad_modulus: assert property (act_config[0] |-> den_eff == 17'h10000)
    else $error("quadrature modulus wrong");
  a_acc_bound: assert property (acc >= 19'sd0 && acc < $signed({2'b00, den_eff}))
    else $error("divider remainder out of range");
  a_gear_drain: assert property (s_ref_fwd |-> ##2 gear_step && !gear_dir)
    else $error("reference pulse not geared");
  a_gear_mode: assert property (!pos_mode && !gear_busy |=> !gear_busy)
    else $error("gear active outside position control");
  a_terms_nonzero: assert property (gear_ratio_numerator != 16'h0000 &&
    gear_ratio_denominator != 16'h0000)
    else $error("gear term zero");
  a_line_pairs: assert property (divided_phase_a_out_n != divided_phase_a_out &&
    divided_phase_b_out_n != divided_phase_b_out)
    else $error("line driver pair not complementary");
  a_div_default: assert property ($rose(presetn) |-> act_divider == 16'h0800)
    else $error("divider default wrong");
endmodule : egd_top
`default_nettype wire

// ### common/egd_pkg.sv
/*
  Constants for the encoder divider and electronic gear block: register map,
  field positions, reset values and encoder resolutions.
  Assumes a 32-bit APB master and byte addresses on paddr.
*/
// Summary of operation
// - Divider setting is 16 bits, 0 to 65535, default 2048.
// - Encoder counts are scaled by the divider before the divided A/B outputs.
// - Serial divider range is 16-2048 (13-bit) or 16-16384 (16-bit).
// - A 13-bit encoder clamps output to 2048 pulses per revolution.
// - Divider change acts only after a restart, never on the write itself.
// - Quadrature mode ratio is setting over 65536, in four-times counts.
// - Quadrature mode setting zero passes every count through one to one.
// - Each reference pulse moves numerator over denominator encoder counts.
// - Gear numerator ranges 1 to 65535, default 4, position control only.
// - Gear denominator ranges 1 to 65535, default 1, position control only.
// - Gear works in quadrature counts; 2048, 16384, 32768 pulses per revolution.
package egd_pkg;
  // Register byte offsets
  localparam logic [11:0] OFS_DIVIDER = 12'h000;
  localparam logic [11:0] OFS_NUMER = 12'h004;
  localparam logic [11:0] OFS_DENOM = 12'h008;
  localparam logic [11:0] OFS_CONFIG = 12'h00C;
  localparam logic [11:0] OFS_CTRL = 12'h010;
  localparam logic [11:0] OFS_STATUS = 12'h014;
  localparam logic [11:0] OFS_POSITION = 12'h018;
  // Reset values
  localparam logic [15:0] RST_DIVIDER = 16'h0800;
  localparam logic [15:0] RST_NUMER = 16'h0004;
  localparam logic [15:0] RST_DENOM = 16'h0001;
  localparam logic [3:0] RST_CONFIG = 4'h0;
  // Config and control fields
  localparam int CFG_QUAD = 0;
  localparam int CFG_RES_LO = 1;
  localparam int CFG_POS_MODE = 3;
  localparam int CTRL_RESTART = 0;
  // Encoder resolution codes and pulses per revolution
  localparam logic [1:0] RES_13 = 2'h0;
  localparam logic [1:0] RES_16 = 2'h1;
  localparam logic [16:0] PPR_13 = 17'h00800;
  localparam logic [16:0] PPR_16 = 17'h04000;
  localparam logic [16:0] PPR_17 = 17'h08000;
  localparam logic [16:0] DIV_MIN = 17'h00010;
  localparam logic [16:0] QUAD_MODULUS = 17'h10000;
  // Divided output phase, Gray ordered
  typedef enum logic [1:0] {PH0 = 2'h0, PH1 = 2'h1, PH2 = 2'h3, PH3 = 2'h2} egd_phase_type;
endpackage : egd_pkg

// ### verif/egd_host.sv
/*
  Host controller model: counts divided quadrature steps and sends
  reference pulses. Assumes the block's outputs are synchronous to pclk.
*/
`timescale 1ns/100ps
`default_nettype none
module egd_host (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Divided quadrature from the block
  input wire logic div_a,
  input wire logic div_b,
  // Reference pulses to the block
  output logic ref_pulse = 1'b0,
  output logic ref_dir = 1'b0,
  // Signed count of divided steps
  output int pos
);
  logic [1:0] last;
  // no index return
  // Up on forward step (A leads B), down on reverse
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      last <= 2'h0;
      pos <= 0;
    end
    else
    begin
      last <= {div_a, div_b};
      if ({~last[0], last[1]} == {div_a, div_b})
        pos <= pos + 1;
      else if ({last[0], ~last[1]} == {div_a, div_b})
        pos <= pos - 1;
    end
  end

  // Sends n one-cycle pulses; direction line is scrambled between pulses
  task automatic send(input int n, input logic dir, input int gap);
    for (int i = 0; i < n; i++)
    begin
      @(posedge pclk);
      ref_pulse <= 1'b1;
      ref_dir <= dir;
      @(posedge pclk);
      ref_pulse <= 1'b0;
      ref_dir <= ~dir;
      repeat (gap) @(posedge pclk);
    end
  endtask : send
endmodule : egd_host
`default_nettype wire

// ### verif/egd_top_tb.sv
/*
  Self-checking bench for the divider and gear block.
  Assumes the host model in egd_host and the package egd_pkg.
*/
`timescale 1ns/100ps
`default_nettype none
module egd_top_tb;
  logic pclk, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic enc_a = 1'b0, enc_b = 1'b0, pready, pslverr, ref_pulse, ref_dir;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000, prdata, q;
  logic divided_phase_a_out, divided_phase_a_out_n, divided_phase_b_out, divided_phase_b_out_n;
  logic gear_step, gear_dir, gear_busy, e;
  int fails = 0, n_tests = 0, pos, gcnt = 0, k0, ph = 0;
  logic [1:0] seq [4] = '{2'h0, 2'h2, 2'h3, 2'h1};
  logic [3:0] tc [8] = '{4'h1, 4'h1, 4'h1, 4'h0, 4'h0, 4'h2, 4'h4, 4'h0};
  logic [15:0] td [8] = '{16'h0000, 16'h4000, 16'h6000, 16'h1000, 16'h0400, 16'h1000, 16'h2000,
    16'h0000};
  int tn [8] = '{8, 16, 16, 8, 8, 16, 16, 256};
  int te [8] = '{8, 4, 6, 8, 4, 4, 4, 2};

  egd_top DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .enc_a, .enc_b, .divided_phase_a_out, .divided_phase_a_out_n,
    .divided_phase_b_out, .divided_phase_b_out_n, .ref_pulse, .ref_dir, .gear_step,
    .gear_dir, .gear_busy);
  egd_host host (.pclk, .presetn, .div_a(divided_phase_a_out), .div_b(divided_phase_b_out),
    .ref_pulse, .ref_dir, .pos);

  // Clock
  initial
  begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  // Signed count of geared steps
  always @(posedge pclk)
    if (gear_step === 1'b1)
      gcnt <= (gear_dir === 1'b1) ? gcnt - 1 : gcnt + 1;

  task automatic wrap_up;
    $display("fails=%0d n_tests=%0d", fails, n_tests);
    if (fails == 0 && n_tests > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : wrap_up

  task automatic chk(input string s, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", s, exp, seen);
    end
  endtask : chk

  // One APB transfer, held until pready is sampled high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      k++;
    end
    while (pready !== 1'b1 && k < 20);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (k >= 20)
    begin
      fails++;
      wrap_up;
    end
  endtask : apb

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task automatic rd(input logic [11:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h00000000);
    chk("read", q, x);
  endtask : rd

  // Encoder steps, one change every two cycles
  task automatic enc(input int n, input logic dir);
    for (int i = 0; i < n; i++)
    begin
      @(posedge pclk);
      ph = (ph + (dir ? 3 : 1)) % 4;
      {enc_a, enc_b} <= seq[ph];
      @(posedge pclk);
    end
    repeat (4) @(posedge pclk);
  endtask : enc

  // Waits for the gear to drain
  task automatic settle;
    int k;
    k = 0;
    repeat (2) @(posedge pclk);
    while (gear_busy !== 1'b0 && k < 300)
    begin
      @(posedge pclk);
      k++;
    end
    if (k >= 300)
    begin
      fails++;
      wrap_up;
    end
    repeat (4) @(posedge pclk);
  endtask : settle

  // Main sequence
  initial
  begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    rd(egd_pkg::OFS_DIVIDER, 32'h00000800);
    rd(egd_pkg::OFS_NUMER, 32'h00000004);
    rd(egd_pkg::OFS_DENOM, 32'h00000001);
    apb(1'b0, 12'h020, 32'h00000000);
    chk("unmapped err", {31'h0, e}, 32'h00000001);
    chk("unmapped data", q, 32'h00000000);
    for (int i = 0; i < 8; i++)
    begin
      wr(egd_pkg::OFS_CONFIG, {28'h0, tc[i]});
      wr(egd_pkg::OFS_DIVIDER, {16'h0, td[i]});
      wr(egd_pkg::OFS_CTRL, 32'h00000001);
      k0 = pos;
      enc(tn[i], 1'b0);
      chk("div fwd", pos - k0, te[i]);
      chk("div pair", {divided_phase_a_out_n, divided_phase_b_out_n}, {~divided_phase_a_out, ~divided_phase_b_out});
      enc(tn[i], 1'b1);
      chk("div back", pos - k0, 0);
    end
    wr(egd_pkg::OFS_DIVIDER, 32'h00000800);
    k0 = pos;
    enc(256, 1'b0);
    chk("div held", pos - k0, 2);
    rd(egd_pkg::OFS_STATUS, 32'h00000000);
    wr(egd_pkg::OFS_CTRL, 32'h00000001);
    rd(egd_pkg::OFS_STATUS, 32'h00000800);
    wr(egd_pkg::OFS_CONFIG, 32'h00000008);
    host.send(1, 1'b0, 2);
    @(negedge pclk);
    chk("gear busy", {31'h0, gear_busy}, 32'h00000001);
    settle;
    chk("gear default", gcnt, 4);
    wr(egd_pkg::OFS_NUMER, 32'h00000003);
    wr(egd_pkg::OFS_DENOM, 32'h00000002);
    host.send(5, 1'b0, 0);
    settle;
    chk("gear frac", gcnt, 11);
    host.send(1, 1'b0, 3);
    settle;
    chk("gear rem", gcnt, 13);
    host.send(6, 1'b1, 0);
    settle;
    chk("gear rev", gcnt, 4);
    rd(egd_pkg::OFS_POSITION, 32'h00000004);
    wr(egd_pkg::OFS_CONFIG, 32'h00000000);
    host.send(2, 1'b0, 0);
    settle;
    chk("gear off", gcnt, 4);
    wr(egd_pkg::OFS_NUMER, 32'h00000000);
    rd(egd_pkg::OFS_NUMER, 32'h00000001);
    wrap_up;
  end
endmodule : egd_top_tb
`default_nettype wire
